// ### rtl/cfgdec_pkg.sv
/*
   Constants, field layout, reset values and carrier types for the configuration
   word decoder.
   Assumes a byte-wide nonvolatile configuration store and table access by byte address.
*/
package cfgdec_pkg;

   localparam int NUM_BYTES = 6;
   localparam int IDX_W = 3;
   localparam int TBL_ADDR_W = 22;

   // byte index of each implemented configuration byte inside the shadow image
   localparam logic [IDX_W-1:0] IDX_OSC = 3'h0;
   localparam logic [IDX_W-1:0] IDX_BOR = 3'h1;
   localparam logic [IDX_W-1:0] IDX_WDT = 3'h2;
   localparam logic [IDX_W-1:0] IDX_PIN = 3'h3;
   localparam logic [IDX_W-1:0] IDX_CORE = 3'h4;
   localparam logic [IDX_W-1:0] IDX_CP = 3'h5;

   localparam logic [TBL_ADDR_W-1:0] CFG_BASE_ADDR = 22'h300000;
   localparam logic [TBL_ADDR_W-1:0] CFG_ADDR [NUM_BYTES] = '{
      22'h300001, 22'h300002, 22'h300003, 22'h300005, 22'h300006, 22'h300008};

   // unprogrammed values and implemented-bit masks per byte
   localparam logic [7:0] CFG_DEFAULT [NUM_BYTES] = '{
      8'h25, 8'h1f, 8'h3f, 8'hbf, 8'h85, 8'h0f};
   localparam logic [7:0] CFG_IMPL [NUM_BYTES] = '{
      8'hff, 8'h1f, 8'h3f, 8'hbf, 8'hc5, 8'h0f};
   localparam logic [7:0] CFG_CLEAR_ONLY [NUM_BYTES] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
   localparam logic [7:0] CFG_HV_ONLY [NUM_BYTES] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};

   // oscillator byte
   localparam int SWITCHOVER_BIT = 7;
   localparam int MONITOR_BIT = 6;
   localparam int PRIMARY_KEEP_BIT = 5;
   localparam int MULT_FORCE_BIT = 4;
   localparam int OSC_SEL_LSB = 0;
   // brown-out / power-up byte
   localparam int BOR_LEVEL_LSB = 3;
   localparam int BOR_MODE_LSB = 1;
   localparam int POWERUP_N_BIT = 0;
   // watchdog byte
   localparam int WDT_PS_LSB = 2;
   localparam int WDT_MODE_LSB = 0;
   // pin routing byte
   localparam int RESET_PIN_BIT = 7;
   localparam int OUT_B_BIT = 5;
   localparam int TIMER_CLK_BIT = 4;
   localparam int FAST_START_BIT = 3;
   localparam int CAPTURE3_BIT = 2;
   localparam int ANALOG_DEF_BIT = 1;
   localparam int CAPTURE2_BIT = 0;
   // core / debug byte
   localparam int DEBUG_N_BIT = 7;
   localparam int EXTENDED_INSTRUCTION_ENABLE_BIT = 6;
   localparam int LVP_BIT = 2;
   localparam int STACK_BIT = 0;

   localparam logic [1:0] BOR_MODE_HW = 2'h3;
   localparam logic [1:0] BOR_MODE_HW_AWAKE = 2'h2;
   localparam logic [1:0] BOR_MODE_SW = 2'h1;
   localparam logic [1:0] BOR_MODE_OFF = 2'h0;
   localparam logic [1:0] WDT_MODE_HW = 2'h3;
   localparam logic [1:0] WDT_MODE_SW = 2'h2;
   localparam logic [1:0] WDT_MODE_AWAKE = 2'h1;
   localparam logic [1:0] WDT_MODE_OFF = 2'h0;

   // nominal trip voltages in millivolts, indexed by level code
   localparam logic [11:0] TRIP_MV [4] = '{12'hb22, 12'h9c4, 12'h898, 12'h76c};
   localparam logic [5:0] ANALOG_ALL = 6'h3f;

   // self-timed write duration in clock cycles, no figure given
   localparam int WRITE_CYCLES = 16;

   typedef enum logic [2:0] {
      OSC_LP, OSC_XT, OSC_HS, OSC_EXT_CLOCK, OSC_RC, OSC_INTERNAL
   } cfgdec_osc_t;

   typedef enum logic [1:0] {PWR_LOW, PWR_MED, PWR_HIGH} cfgdec_power_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [TBL_ADDR_W-1:0] addr;
      logic [7:0] data;
   } cfgdec_tbl_req_t;

   typedef struct packed {
      logic switchoverEnable;
      logic clockMonitorEnable;
      logic primaryClockKeep;
      logic multiplierForce;
      cfgdec_osc_t oscSource;
      cfgdec_power_t drivePower;
      logic clockOutOsc2;
      logic clockOutPortPin;
      logic [1:0] brownoutLevel;
      logic [11:0] brownoutTripMv;
      logic [1:0] brownoutMode;
      logic powerupTimerOn;
      logic [15:0] watchdogRatio;
      logic [1:0] watchdogMode;
      logic resetPinEnable;
      logic timerClockRouting;
      logic fastStart;
      logic [5:0] portBAnalogReset;
      logic capture2Routing;
      logic capture3Routing;
      logic enhancedOutBRouting;
      logic debuggerOn;
      logic extendedInstructionEnable;
      logic singleSupplyProgEnable;
      logic stackFaultResetEnable;
      logic [3:0] codeBlockProtected;
   } cfgdec_ctrl_t;

endpackage

// ### rtl/cfgdec_cfg_byte.sv
/*
   One configuration byte shadow: loaded from the nonvolatile store, updated by
   table writes with clear-only and high-voltage-only bit handling.
   Assumes load and write never come in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module cfgdec_cfg_byte #(
   parameter logic [7:0] IMPL_MASK = 8'hff,
   parameter logic [7:0] DEFAULT = 8'hff,
   parameter logic [7:0] CLEAR_ONLY = 8'h00,
   parameter logic [7:0] HV_ONLY = 8'h00
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [7:0] loadData,
   input wire logic loadProgrammed,
   input wire logic write,
   input wire logic [7:0] writeData,
   input wire logic hvProgMode,
   output logic [7:0] value
);

   typedef struct packed {
      logic [7:0] value;
   } cfgdec_byte_state_t;

   cfgdec_byte_state_t state;
   cfgdec_byte_state_t next_state;
   logic [7:0] merged;

   always_comb begin
      next_state = state;
      merged = writeData;
      // clear-only cells can drop to 0 but a 1 can never be written back
      merged = (merged & ~CLEAR_ONLY) | (state.value & writeData & CLEAR_ONLY);
      merged = hvProgMode ? merged : ((merged & ~HV_ONLY) | (state.value & HV_ONLY));
      if (load) begin
         next_state.value = (loadProgrammed ? loadData : DEFAULT) & IMPL_MASK;
      end else if (write) begin
         next_state.value = merged & IMPL_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '{value: DEFAULT & IMPL_MASK};
      end else begin
         state <= next_state;
      end
   end

   assign value = state.value;

endmodule

`default_nettype wire

// ### rtl/cfgdec_decoder.sv
/*
   Configuration word decoder top: loads the configuration bytes after reset,
   decodes them into static controls and serves table reads and self-timed writes.
   Assumes a nonvolatile store answering one cycle after the read address and
   inputs synchronous to ref_clk.
*/
// How it works
// - switchover bit enables oscillator switchover mode
// - monitor bit turns fail-safe clock monitor on
// - keep bit forces primary clock always on
// - force bit or software bit runs multiplier
// - select field picks crystal, external clock, RC or internal
// - external clock codes set power, even add output
// - level field picks brown-out trip voltage
// - brown-out mode; software bit only in mode 01
// - power-up timer enable is active low
// - watchdog ratio is two to field value
// - watchdog mode; software bit only in mode 10
// - routing bit steers third timer clock pin
// - fast start releases CPU clock at once
// - analog default sets port B analog reset
// - capture routing bits pick alternate port pins
// - debugger enable active low, dedicates two pins
// - extended instruction bit enables indexed addressing
// - low-voltage programming bit, high-voltage changes only
// - stack fault reset enable gates stack reset
// - code protect bits active low, clearable only
// - bytes at 300000h upward, table access, byte writes
`timescale 1ns/1ps
`default_nettype none

module cfgdec_decoder #(
   parameter int WRITE_CYCLES = cfgdec_pkg::WRITE_CYCLES,
   parameter int CODE_BLOCKS = 4
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire cfgdec_pkg::cfgdec_tbl_req_t tblReq,
   output logic [7:0] tblRdData,
   output logic tblAck,
   output logic tblBusy,
   output logic nvRdEn,
   output logic [cfgdec_pkg::TBL_ADDR_W-1:0] nvRdAddr,
   input wire logic [7:0] nvRdData,
   input wire logic nvRdProgrammed,
   output logic nvWrEn,
   output logic [cfgdec_pkg::TBL_ADDR_W-1:0] nvWrAddr,
   output logic [7:0] nvWrData,
   input wire logic hvProgMode,
   input wire logic softwarePrimaryClockEnable,
   input wire logic softwareMultiplierEnable,
   input wire logic softwareBrownoutBit,
   input wire logic softwareWatchdogBit,
   input wire logic sleepMode,
   input wire logic sharedResetPin,
   input wire logic highFreqOscStable,
   input wire logic stackFault,
   output cfgdec_pkg::cfgdec_ctrl_t ctrl,
   output logic configReady,
   output logic primaryClockOn,
   output logic multiplierOn,
   output logic brownoutActive,
   output logic watchdogActive,
   output logic externalResetAssert,
   output logic portPinData,
   output logic cpuClockRelease,
   output logic stackResetRequest
);

   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_CYCLES - 1);
   localparam int ACK_BOUND = WRITE_CYCLES + 1;

   typedef enum logic [1:0] {PH_LOAD, PH_DECODE, PH_RUN, PH_WRITE} cfgdec_phase_t;

   typedef struct packed {
      cfgdec_phase_t phase;
      logic [cfgdec_pkg::IDX_W-1:0] loadIdx;
      logic fetchPending;
      logic [CNT_W-1:0] writeCount;
      logic [cfgdec_pkg::IDX_W-1:0] writeIdx;
      logic [7:0] tblRdData;
      logic tblAck;
      logic tblBusy;
      logic nvRdEn;
      logic [cfgdec_pkg::TBL_ADDR_W-1:0] nvRdAddr;
      logic nvWrEn;
      logic [cfgdec_pkg::TBL_ADDR_W-1:0] nvWrAddr;
      logic [7:0] nvWrData;
      cfgdec_pkg::cfgdec_ctrl_t ctrl;
      logic configReady;
      logic primaryClockOn;
      logic multiplierOn;
      logic brownoutActive;
      logic watchdogActive;
      logic externalResetAssert;
      logic portPinData;
      logic cpuClockRelease;
      logic stackResetRequest;
   } cfgdec_state_t;

   cfgdec_state_t state;
   cfgdec_state_t next_state;
   logic [cfgdec_pkg::NUM_BYTES-1:0][7:0] image;
   logic [cfgdec_pkg::NUM_BYTES-1:0] loadStrobe;
   logic [cfgdec_pkg::NUM_BYTES-1:0] writeStrobe;
   logic hit;
   logic [cfgdec_pkg::IDX_W-1:0] hitIdx;
   logic startWrite;

   genvar g;
   generate
      for (g = 0; g < cfgdec_pkg::NUM_BYTES; g++) begin : gen_byte
         cfgdec_cfg_byte #(
            .IMPL_MASK(cfgdec_pkg::CFG_IMPL[g]),
            .DEFAULT(cfgdec_pkg::CFG_DEFAULT[g]),
            .CLEAR_ONLY(cfgdec_pkg::CFG_CLEAR_ONLY[g]),
            .HV_ONLY(cfgdec_pkg::CFG_HV_ONLY[g])
         ) u_byte (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .load(loadStrobe[g]),
            .loadData(nvRdData),
            .loadProgrammed(nvRdProgrammed),
            .write(writeStrobe[g]),
            .writeData(tblReq.data),
            .hvProgMode(hvProgMode),
            .value(image[g])
         );
      end
   endgenerate

   function automatic cfgdec_pkg::cfgdec_ctrl_t decodeImage(
      input logic [cfgdec_pkg::NUM_BYTES-1:0][7:0] img
   );
      cfgdec_pkg::cfgdec_ctrl_t c;
      logic [7:0] osc;
      logic [7:0] bor;
      logic [7:0] wdt;
      logic [7:0] pin;
      logic [7:0] core;
      logic [7:0] cp;
      c = '0;
      osc = img[cfgdec_pkg::IDX_OSC];
      bor = img[cfgdec_pkg::IDX_BOR];
      wdt = img[cfgdec_pkg::IDX_WDT];
      pin = img[cfgdec_pkg::IDX_PIN];
      core = img[cfgdec_pkg::IDX_CORE];
      cp = img[cfgdec_pkg::IDX_CP];
      c.switchoverEnable = osc[cfgdec_pkg::SWITCHOVER_BIT];
      c.clockMonitorEnable = osc[cfgdec_pkg::MONITOR_BIT];
      c.primaryClockKeep = osc[cfgdec_pkg::PRIMARY_KEEP_BIT];
      c.multiplierForce = osc[cfgdec_pkg::MULT_FORCE_BIT];
      c.drivePower = cfgdec_pkg::PWR_MED;
      unique case (osc[cfgdec_pkg::OSC_SEL_LSB +: 4])
         4'hf, 4'he: begin
            c.oscSource = cfgdec_pkg::OSC_RC;
            c.clockOutPortPin = 1'b1;
         end
         4'hd, 4'hc: begin
            c.oscSource = cfgdec_pkg::OSC_EXT_CLOCK;
            c.drivePower = cfgdec_pkg::PWR_LOW;
         end
         4'hb, 4'ha: c.oscSource = cfgdec_pkg::OSC_EXT_CLOCK;
         4'h9, 4'h8: c.oscSource = cfgdec_pkg::OSC_INTERNAL;
         4'h7, 4'h6: c.oscSource = cfgdec_pkg::OSC_RC;
         4'h5, 4'h4: begin
            c.oscSource = cfgdec_pkg::OSC_EXT_CLOCK;
            c.drivePower = cfgdec_pkg::PWR_HIGH;
         end
         4'h3: c.oscSource = cfgdec_pkg::OSC_HS;
         4'h2: begin
            c.oscSource = cfgdec_pkg::OSC_HS;
            c.drivePower = cfgdec_pkg::PWR_HIGH;
         end
         4'h1: c.oscSource = cfgdec_pkg::OSC_XT;
         4'h0: c.oscSource = cfgdec_pkg::OSC_LP;
      endcase
      // clock output on the oscillator pin for the even external, RC-6 and internal-9 codes
      c.clockOutOsc2 = !c.clockOutPortPin && (osc[3:0] inside {4'hc, 4'ha, 4'h9, 4'h6, 4'h4});
      c.brownoutLevel = bor[cfgdec_pkg::BOR_LEVEL_LSB +: 2];
      c.brownoutTripMv = cfgdec_pkg::TRIP_MV[bor[cfgdec_pkg::BOR_LEVEL_LSB +: 2]];
      c.brownoutMode = bor[cfgdec_pkg::BOR_MODE_LSB +: 2];
      c.powerupTimerOn = !bor[cfgdec_pkg::POWERUP_N_BIT];
      c.watchdogRatio = 16'h0001 << wdt[cfgdec_pkg::WDT_PS_LSB +: 4];
      c.watchdogMode = wdt[cfgdec_pkg::WDT_MODE_LSB +: 2];
      c.resetPinEnable = pin[cfgdec_pkg::RESET_PIN_BIT];
      c.timerClockRouting = pin[cfgdec_pkg::TIMER_CLK_BIT];
      c.fastStart = pin[cfgdec_pkg::FAST_START_BIT];
      c.portBAnalogReset = pin[cfgdec_pkg::ANALOG_DEF_BIT] ? cfgdec_pkg::ANALOG_ALL : 6'h00;
      c.capture2Routing = pin[cfgdec_pkg::CAPTURE2_BIT];
      c.capture3Routing = pin[cfgdec_pkg::CAPTURE3_BIT];
      c.enhancedOutBRouting = pin[cfgdec_pkg::OUT_B_BIT];
      c.debuggerOn = !core[cfgdec_pkg::DEBUG_N_BIT];
      c.extendedInstructionEnable = core[cfgdec_pkg::EXTENDED_INSTRUCTION_ENABLE_BIT];
      c.singleSupplyProgEnable = core[cfgdec_pkg::LVP_BIT];
      c.stackFaultResetEnable = core[cfgdec_pkg::STACK_BIT];
      for (int i = 0; i < 4; i++) begin
         // blocks missing on smaller memories are never reported protected
         c.codeBlockProtected[i] = (i < CODE_BLOCKS) && !cp[i];
      end
      return c;
   endfunction

   always_comb begin
      hit = 1'b0;
      hitIdx = '0;
      for (int i = 0; i < cfgdec_pkg::NUM_BYTES; i++) begin
         if (tblReq.addr == cfgdec_pkg::CFG_ADDR[i]) begin
            hit = 1'b1;
            hitIdx = cfgdec_pkg::IDX_W'(i);
         end
      end
   end

   assign startWrite = (state.phase == PH_RUN) && tblReq.req && tblReq.write && hit;

   always_comb begin
      next_state = state;
      next_state.tblAck = 1'b0;
      next_state.nvWrEn = 1'b0;
      loadStrobe = '0;
      writeStrobe = '0;
      unique case (state.phase)
         PH_LOAD: begin
            next_state.nvRdEn = 1'b1;
            next_state.fetchPending = !state.fetchPending;
            if (state.fetchPending) begin
               loadStrobe[state.loadIdx] = 1'b1;
               if (state.loadIdx == cfgdec_pkg::IDX_W'(cfgdec_pkg::NUM_BYTES - 1)) begin
                  next_state.phase = PH_DECODE;
                  next_state.nvRdEn = 1'b0;
               end else begin
                  next_state.loadIdx = state.loadIdx + 3'h1;
                  next_state.nvRdAddr = cfgdec_pkg::CFG_ADDR[state.loadIdx + 3'h1];
               end
            end
         end
         PH_DECODE: begin
            // the only place ctrl is written: later writes reach it after the next reset
            next_state.ctrl = decodeImage(image);
            next_state.configReady = 1'b1;
            next_state.phase = PH_RUN;
         end
         PH_RUN: begin
            if (tblReq.req && !tblReq.write) begin
               next_state.tblAck = 1'b1;
               next_state.tblRdData = hit ? image[hitIdx] : 8'h00;
            end else if (startWrite) begin
               writeStrobe[hitIdx] = 1'b1;
               next_state.writeIdx = hitIdx;
               next_state.writeCount = WRITE_LAST;
               next_state.phase = PH_WRITE;
            end else if (tblReq.req) begin
               next_state.tblAck = 1'b1;
            end
         end
         PH_WRITE: begin
            if (state.writeCount == '0) begin
               // self-timed write ends by committing the merged byte to the store
               next_state.nvWrEn = 1'b1;
               next_state.nvWrAddr = cfgdec_pkg::CFG_ADDR[state.writeIdx];
               next_state.nvWrData = image[state.writeIdx];
               next_state.tblAck = 1'b1;
               next_state.phase = PH_RUN;
            end else begin
               next_state.writeCount = state.writeCount - CNT_W'(1);
            end
         end
      endcase
      next_state.tblBusy = (next_state.phase != PH_RUN);
      if (state.configReady) begin
         next_state.primaryClockOn = state.ctrl.primaryClockKeep || softwarePrimaryClockEnable;
         next_state.multiplierOn = state.ctrl.multiplierForce || softwareMultiplierEnable;
         unique case (state.ctrl.brownoutMode)
            cfgdec_pkg::BOR_MODE_HW: next_state.brownoutActive = 1'b1;
            cfgdec_pkg::BOR_MODE_HW_AWAKE: next_state.brownoutActive = !sleepMode;
            cfgdec_pkg::BOR_MODE_SW: next_state.brownoutActive = softwareBrownoutBit;
            cfgdec_pkg::BOR_MODE_OFF: next_state.brownoutActive = 1'b0;
         endcase
         unique case (state.ctrl.watchdogMode)
            cfgdec_pkg::WDT_MODE_HW: next_state.watchdogActive = 1'b1;
            cfgdec_pkg::WDT_MODE_SW: next_state.watchdogActive = softwareWatchdogBit;
            cfgdec_pkg::WDT_MODE_AWAKE: next_state.watchdogActive = !sleepMode;
            cfgdec_pkg::WDT_MODE_OFF: next_state.watchdogActive = 1'b0;
         endcase
         next_state.externalResetAssert = state.ctrl.resetPinEnable && !sharedResetPin;
         next_state.portPinData = !state.ctrl.resetPinEnable && sharedResetPin;
         next_state.cpuClockRelease = state.ctrl.fastStart || highFreqOscStable;
         next_state.stackResetRequest = state.ctrl.stackFaultResetEnable && stackFault;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
         state.phase <= PH_LOAD;
         state.tblBusy <= 1'b1;
         state.nvRdAddr <= cfgdec_pkg::CFG_BASE_ADDR + 22'h000001;
      end else begin
         state <= next_state;
      end
   end

   assign tblRdData = state.tblRdData;
   assign tblAck = state.tblAck;
   assign tblBusy = state.tblBusy;
   assign nvRdEn = state.nvRdEn;
   assign nvRdAddr = state.nvRdAddr;
   assign nvWrEn = state.nvWrEn;
   assign nvWrAddr = state.nvWrAddr;
   assign nvWrData = state.nvWrData;
   assign ctrl = state.ctrl;
   assign configReady = state.configReady;
   assign primaryClockOn = state.primaryClockOn;
   assign multiplierOn = state.multiplierOn;
   assign brownoutActive = state.brownoutActive;
   assign watchdogActive = state.watchdogActive;
   assign externalResetAssert = state.externalResetAssert;
   assign portPinData = state.portPinData;
   assign cpuClockRelease = state.cpuClockRelease;
   assign stackResetRequest = state.stackResetRequest;

   a_ctrl_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady && $past(configReady) |-> $stable(ctrl))
      else $error("decoded controls changed after load");

   a_multiplier_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady |=> multiplierOn == ($past(ctrl.multiplierForce) || $past(softwareMultiplierEnable)))
      else $error("multiplier output wrong");

   a_brownout_soft: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady && $past(configReady) && ctrl.brownoutMode != cfgdec_pkg::BOR_MODE_SW
      && $changed(softwareBrownoutBit) && $stable(sleepMode) |=> $stable(brownoutActive))
      else $error("software brown-out bit leaked outside mode 01");

   a_watchdog_soft: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady && ctrl.watchdogMode == cfgdec_pkg::WDT_MODE_SW
      |=> watchdogActive == $past(softwareWatchdogBit))
      else $error("watchdog not following software bit");

   a_watchdog_sleep: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady && ctrl.watchdogMode == cfgdec_pkg::WDT_MODE_AWAKE ##1 sleepMode
      |=> !watchdogActive)
      else $error("watchdog on in sleep");

   a_ratio_onehot: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady |-> $onehot(ctrl.watchdogRatio))
      else $error("watchdog ratio not a power of two");

   a_write_done: assert property (@(posedge ref_clk) disable iff (!reset_n)
      startWrite |=> tblBusy ##[1:ACK_BOUND] (tblAck && nvWrEn))
      else $error("self-timed write did not finish in time");

   a_reset_pin_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady && ctrl.resetPinEnable |=> !portPinData)
      else $error("port input seen while pin is reset");

   a_protect_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
      configReady && $past(configReady)
      |-> (image[cfgdec_pkg::IDX_CP] & ~$past(image[cfgdec_pkg::IDX_CP])) == 8'h00)
      else $error("code protect bit set by write");

   a_load_time: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(nvRdEn) |-> ##[12:13] configReady)
      else $error("load did not finish in time");

endmodule

`default_nettype wire

// ### testbench/tb_config_word_decoder.sv
/* bench for the configuration word decoder: random store images, readback, decode, writes.
   assumes WRITE_CYCLES of 2 and a store that answers on the edge after its address. */
`timescale 1ns/1ps
`default_nettype none
module tb_config_word_decoder;
   logic ref_clk = 0, reset_n = 0, nvRdProgrammed = 0, hvProgMode = 0;
   logic tblAck, tblBusy, nvRdEn, nvWrEn, configReady;
   logic [7:0] tblRdData, nvRdData = 0, nvWrData, o, b, w, p, c, k, d, sw = 0, live;
   logic [21:0] nvRdAddr, nvWrAddr;
   logic [7:0] img [6];
   logic [5:0] prog;
   logic [11:0] mv [4] = '{12'hb22, 12'h9c4, 12'h898, 12'h76c};
   cfgdec_pkg::cfgdec_tbl_req_t tblReq = '0;
   cfgdec_pkg::cfgdec_ctrl_t ctrl;
   int failures = 0, check_count = 0, seed = 32'ha4a962e2, n;
   cfgdec_decoder #(.WRITE_CYCLES(2), .CODE_BLOCKS(4)) u_dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .tblReq(tblReq), .tblRdData(tblRdData), .tblAck(tblAck),
      .tblBusy(tblBusy), .nvRdEn(nvRdEn), .nvRdAddr(nvRdAddr), .nvRdData(nvRdData),
      .nvRdProgrammed(nvRdProgrammed), .nvWrEn(nvWrEn), .nvWrAddr(nvWrAddr),
      .nvWrData(nvWrData), .hvProgMode(hvProgMode), .softwarePrimaryClockEnable(sw[0]),
      .softwareMultiplierEnable(sw[1]), .softwareBrownoutBit(sw[2]),
      .softwareWatchdogBit(sw[3]), .sleepMode(sw[4]), .sharedResetPin(sw[5]),
      .highFreqOscStable(sw[6]), .stackFault(sw[7]), .ctrl(ctrl), .configReady(configReady),
      .primaryClockOn(live[0]), .multiplierOn(live[1]), .brownoutActive(live[2]),
      .watchdogActive(live[3]), .externalResetAssert(live[4]), .portPinData(live[5]),
      .cpuClockRelease(live[6]), .stackResetRequest(live[7]));
   initial forever #25 ref_clk = ~ref_clk;
   // unprogrammed bytes still carry random data, so a design ignoring the flag is caught
   always @(negedge ref_clk) begin
      nvRdData = 8'h00;
      nvRdProgrammed = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (nvRdEn === 1'b1 && nvRdAddr === cfgdec_pkg::CFG_ADDR[i]) begin
            nvRdData = img[i];
            nvRdProgrammed = prog[i];
         end
      end
   end
   function automatic logic [7:0] expb(input int i);
      return prog[i] ? img[i] & cfgdec_pkg::CFG_IMPL[i] : cfgdec_pkg::CFG_DEFAULT[i];
   endfunction
   function automatic logic [6:0] oscExp(input logic [3:0] f);
      logic [2:0] s;
      logic [1:0] pw;
      pw = cfgdec_pkg::PWR_MED;
      s = cfgdec_pkg::OSC_EXT_CLOCK;
      if ((f >= 4'he) || (f inside {4'h7, 4'h6})) s = cfgdec_pkg::OSC_RC;
      if (f inside {4'h9, 4'h8}) s = cfgdec_pkg::OSC_INTERNAL;
      if (f inside {4'h3, 4'h2}) s = cfgdec_pkg::OSC_HS;
      if (f == 4'h1) s = cfgdec_pkg::OSC_XT;
      if (f == 4'h0) s = cfgdec_pkg::OSC_LP;
      if (f inside {4'hd, 4'hc}) pw = cfgdec_pkg::PWR_LOW;
      if (f inside {4'h5, 4'h4, 4'h2}) pw = cfgdec_pkg::PWR_HIGH;
      return {s, pw, (f inside {4'hc, 4'ha, 4'h9, 4'h6, 4'h4}), (f >= 4'he)};
   endfunction
   function automatic logic [7:0] liveExp();
      logic [3:0] bm, wm;
      bm = {1'b1, !sw[4], sw[2], 1'b0};
      wm = {1'b1, sw[3], !sw[4], 1'b0};
      return {c[0] & sw[7], p[3] | sw[6], !p[7] & sw[5], p[7] & !sw[5], wm[w[1:0]],
         bm[b[2:1]], o[4] | sw[1], o[5] | sw[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("TB: %0d checks, %0d failures", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic tbl(input logic wr, input logic [21:0] a, input logic [7:0] dt);
      n = 0;
      @(negedge ref_clk);
      tblReq = '{1'b1, wr, a, dt};
      @(negedge ref_clk);
      tblReq.req = 1'b0;
      while (tblAck !== 1'b1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      check(n, wr ? 2 : 0);
      check(nvWrEn, wr);
      if (wr) check(nvWrAddr, a);
   endtask
   task automatic boot(input logic blank);
      @(negedge ref_clk);
      reset_n = 0;
      for (int i = 0; i < 6; i++) img[i] = 8'($random(seed));
      if (img[0][6] && img[0][3:0] < 4'h4) img[0][7] = 1'b1;
      prog = blank ? 6'h00 : 6'($random(seed));
      sw = 8'($random(seed));
      hvProgMode = 1'($random(seed));
      repeat (20) @(negedge ref_clk);
      reset_n = 1;
      repeat (13) @(negedge ref_clk);
      check({configReady, nvRdEn, tblBusy}, 3'h4);
      repeat (2) @(negedge ref_clk);
      {o, b, w, p, c, k} = {expb(0), expb(1), expb(2), expb(3), expb(4), expb(5)};
   endtask
   initial begin
      #1000000;
      failures++;
      complete_run();
   end
   initial begin
      for (int r = 0; r < 5; r++) begin
         boot(r == 0);
         for (int i = 0; i < 6; i++) begin
            tbl(0, cfgdec_pkg::CFG_ADDR[i], 0);
            check(tblRdData, expb(i));
         end
         check({ctrl.switchoverEnable, ctrl.clockMonitorEnable}, o[7:6]);
         check({ctrl.brownoutLevel, !ctrl.powerupTimerOn}, b[4:3] * 2 + b[0]);
         check(ctrl.brownoutTripMv, mv[b[4:3]]);
         check({ctrl.oscSource, ctrl.drivePower, ctrl.clockOutOsc2, ctrl.clockOutPortPin},
            oscExp(o[3:0]));
         check({ctrl.primaryClockKeep, ctrl.multiplierForce, ctrl.brownoutMode, ctrl.watchdogMode,
            ctrl.fastStart, ctrl.singleSupplyProgEnable, ctrl.stackFaultResetEnable},
            {o[5:4], b[2:1], w[1:0], p[3], c[2], c[0]});
         check(ctrl.watchdogRatio, 16'h1 << w[5:2]);
         check({ctrl.resetPinEnable, ctrl.timerClockRouting}, {p[7], p[4]});
         check(ctrl.portBAnalogReset, {6{p[1]}});
         check({ctrl.enhancedOutBRouting, ctrl.capture3Routing, ctrl.capture2Routing},
            {p[5], p[2], p[0]});
         check({ctrl.debuggerOn, ctrl.extendedInstructionEnable}, {!c[7], c[6]});
         check(ctrl.codeBlockProtected, k[3:0] ^ 4'hf);
         check(live, liveExp());
         // live inputs change mid-run so the gating of each software bit is exercised
         repeat (8) begin
            @(negedge ref_clk);
            sw = 8'($random(seed));
            @(negedge ref_clk);
            check(live, liveExp());
         end
         tbl(0, 22'h300004, 0);
         check(tblRdData, 0);
         d = 8'($random(seed));
         tbl(1, cfgdec_pkg::CFG_ADDR[5], d);
         check(nvWrData, k & d & 8'h0f);
         tbl(0, cfgdec_pkg::CFG_ADDR[5], 0);
         check(tblRdData, k & d & 8'h0f);
         tbl(1, cfgdec_pkg::CFG_ADDR[4], d);
         tbl(0, cfgdec_pkg::CFG_ADDR[4], 0);
         check(tblRdData, hvProgMode ? d & 8'hc5 : (d & 8'hc1) | (c & 8'h04));
         check(ctrl.codeBlockProtected, k[3:0] ^ 4'hf);
         $display("TB: test %0d done", r);
      end
      complete_run();
   end
endmodule
`default_nettype wire
